/* File: src/three_phase_pwm_gen_regs.sv */
// three-phase pwm generator with its duty, state, period and control registers
// assumes the serial interface decodes frames on clk and presents one-cycle strobes
`timescale 1ns/1ps
module three_phase_pwm_gen_regs
  import pwm_gen_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              serial_check_enable,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  output logic      [DATA_W-1:0] reg_rdata,
  output logic      [NPH-1:0]    hs_drive,
  output logic      [NPH-1:0]    ls_drive,
  output logic                   gen_active
);
  typedef struct packed {
    logic [NPH-1:0][VAL_W-1:0] duty;
    logic [NPH-1:0][SEL_W-1:0] sel;
    logic [VAL_W-1:0]          period;
    logic                      en;
    logic [1:0]                cmode;
    logic [2:0]                sync_src;
    logic [2:0]                sclk_sel;
    logic [1:0]                acc;
    logic [VAL_W-1:0]          cnt;
    logic                      down;
    logic [NPH-1:0]            hs;
    logic [NPH-1:0]            ls;
    logic [DATA_W-1:0]         rdata;
  } state_t;

  state_t st_ff;
  state_t nxt_st;
  logic [DATA_W-1:0] rd_word;
  logic [DATA_W-1:0] sel_word;
  logic [DATA_W-1:0] ctrl_word;

  drive_if dif ();

  phase_drive u_drive (
    .d (dif.drv)
  );

  // pwm level per phase; idle low while disabled
  genvar i;
  generate
    for (i = 0; i < NPH; i++) begin : g_pwm
      assign dif.sel[i] = st_ff.sel[i];
      assign dif.pwm[i] = st_ff.en && (st_ff.cnt < st_ff.duty[i]);
    end
  endgenerate

  // assembled read words; unused bits stay zero
  always_comb begin
    sel_word = '0;
    sel_word[SEL_A_LSB +: SEL_W] = st_ff.sel[0];
    sel_word[SEL_B_LSB +: SEL_W] = st_ff.sel[1];
    sel_word[SEL_C_LSB +: SEL_W] = st_ff.sel[2];
    ctrl_word = '0;
    ctrl_word[EN_BIT]           = st_ff.en;
    ctrl_word[CMODE_LSB +: 2]   = st_ff.cmode;
    ctrl_word[SYNC_LSB +: 3]    = st_ff.sync_src;
    ctrl_word[SCLK_LSB +: 3]    = st_ff.sclk_sel;
    ctrl_word[ACC_LSB +: 2]     = st_ff.acc;
    rd_word = '0;
    case (reg_addr)
      OFS_PERIOD: rd_word[VAL_W-1:0] = st_ff.period;
      OFS_DUTY_A: rd_word[VAL_W-1:0] = st_ff.duty[0];
      OFS_DUTY_B: rd_word[VAL_W-1:0] = st_ff.duty[1];
      OFS_DUTY_C: rd_word[VAL_W-1:0] = st_ff.duty[2];
      OFS_STATE:  rd_word = sel_word;
      OFS_CTRL:   rd_word = ctrl_word;
      default:    rd_word = '0; // unmapped reads as zero
    endcase
    // even parity over the whole word, so the host can check a frame
    rd_word[PAR_BIT] = serial_check_enable & (^rd_word[PAR_BIT-1:0]);
  end

  // next state: register writes, counter, registered drive outputs
  always_comb begin
    nxt_st = st_ff;
    if (reg_rd) begin
      nxt_st.rdata = rd_word;
    end
    if (reg_wr) begin
      case (reg_addr)
        OFS_PERIOD: nxt_st.period = reg_wdata[VAL_W-1:0];
        OFS_DUTY_A: nxt_st.duty[0] = reg_wdata[VAL_W-1:0];
        OFS_DUTY_B: nxt_st.duty[1] = reg_wdata[VAL_W-1:0];
        OFS_DUTY_C: nxt_st.duty[2] = reg_wdata[VAL_W-1:0];
        OFS_STATE: begin
          nxt_st.sel[0] = reg_wdata[SEL_A_LSB +: SEL_W];
          nxt_st.sel[1] = reg_wdata[SEL_B_LSB +: SEL_W];
          nxt_st.sel[2] = reg_wdata[SEL_C_LSB +: SEL_W];
        end
        OFS_CTRL: begin
          nxt_st.en       = reg_wdata[EN_BIT];
          nxt_st.cmode    = reg_wdata[CMODE_LSB +: 2];
          nxt_st.sync_src = reg_wdata[SYNC_LSB +: 3];
          nxt_st.sclk_sel = reg_wdata[SCLK_LSB +: 3];
          nxt_st.acc      = reg_wdata[ACC_LSB +: 2];
        end
        default: ;
      endcase
    end
    // counter; a disabled generator parks at zero counting up
    if (!st_ff.en) begin
      nxt_st.cnt  = CNT_ZERO;
      nxt_st.down = 1'b0;
    end else begin
      case (st_ff.cmode)
        CNT_UP: begin
          nxt_st.down = 1'b0;
          nxt_st.cnt  = (st_ff.cnt >= st_ff.period) ? CNT_ZERO : st_ff.cnt + CNT_ONE;
        end
        CNT_DOWN: begin
          nxt_st.down = 1'b1;
          nxt_st.cnt  = (st_ff.cnt == CNT_ZERO || st_ff.cnt > st_ff.period) ? st_ff.period
                                                                           : st_ff.cnt - CNT_ONE;
        end
        CNT_UPDOWN: begin
          if (!st_ff.down) begin
            if (st_ff.cnt >= st_ff.period) begin
              nxt_st.down = 1'b1;
              nxt_st.cnt  = (st_ff.cnt == CNT_ZERO) ? CNT_ZERO : st_ff.cnt - CNT_ONE;
            end else begin
              nxt_st.cnt = st_ff.cnt + CNT_ONE;
            end
          end else if (st_ff.cnt == CNT_ZERO) begin
            nxt_st.down = 1'b0;
            nxt_st.cnt  = (st_ff.period == CNT_ZERO) ? CNT_ZERO : CNT_ONE;
          end else begin
            nxt_st.cnt = st_ff.cnt - CNT_ONE;
          end
        end
        default: nxt_st.cnt = st_ff.cnt; // hold mode freezes the count
      endcase
    end
    // switch commands registered, so outputs never glitch on decode
    nxt_st.hs = dif.hs;
    nxt_st.ls = dif.ls;
  end

  // state register; reset values match the register defaults
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_ff          <= '0;
      st_ff.duty     <= {NPH{RST_DUTY[VAL_W-1:0]}};
      st_ff.sel[0]   <= RST_STATE[SEL_A_LSB +: SEL_W];
      st_ff.sel[1]   <= RST_STATE[SEL_B_LSB +: SEL_W];
      st_ff.sel[2]   <= RST_STATE[SEL_C_LSB +: SEL_W];
      st_ff.period   <= RST_PERIOD;
      st_ff.en       <= RST_CTRL[EN_BIT];
      st_ff.cmode    <= RST_CTRL[CMODE_LSB +: 2];
      st_ff.sync_src <= RST_CTRL[SYNC_LSB +: 3];
      st_ff.sclk_sel <= RST_CTRL[SCLK_LSB +: 3];
      st_ff.acc      <= RST_CTRL[ACC_LSB +: 2];
      // reset selectors are complementary with pwm low, so the low sides start on
      st_ff.ls       <= '1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata  = st_ff.rdata;
  assign hs_drive   = st_ff.hs;
  assign ls_drive   = st_ff.ls;
  assign gen_active = st_ff.en;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_read(logic [7:0] a);
    reg_rd && reg_addr == a;
  endsequence

  property p_duty_wr;
    reg_wr && reg_addr == OFS_DUTY_B |=> st_ff.duty[1] == $past(reg_wdata[VAL_W-1:0]);
  endproperty
  a_duty_wr: assert property (p_duty_wr) else $error("duty write not stored");

  property p_parity;
    reg_rd |=> reg_rdata[PAR_BIT] == ($past(serial_check_enable) & (^reg_rdata[PAR_BIT-1:0]));
  endproperty
  a_parity: assert property (p_parity) else $error("bad parity bit");

  property p_duty_rsv;
    s_read(OFS_DUTY_A) |=> reg_rdata[14:12] == 3'h0 && reg_rdata[11:0] == $past(st_ff.duty[0]);
  endproperty
  a_duty_rsv: assert property (p_duty_rsv) else $error("duty read wrong");

  property p_state_rsv;
    s_read(OFS_STATE) |=> reg_rdata[14:11] == 4'h0 && !reg_rdata[7] && !reg_rdata[3];
  endproperty
  a_state_rsv: assert property (p_state_rsv) else $error("state reserved bits set");

  property p_off;
    $past(st_ff.sel[0]) == DRV_OFF |-> !hs_drive[0] && !ls_drive[0];
  endproperty
  a_off: assert property (p_off) else $error("phase a not off");

  property p_ls_on;
    $past(st_ff.sel[1]) == DRV_LS_ON |-> !hs_drive[1] && ls_drive[1];
  endproperty
  a_ls_on: assert property (p_ls_on) else $error("phase b low side not on");

  property p_hs_on;
    $past(st_ff.sel[2]) == DRV_HS_ON |-> hs_drive[2] && !ls_drive[2];
  endproperty
  a_hs_on: assert property (p_hs_on) else $error("phase c high side not on");

  property p_compl;
    $past(st_ff.sel[0]) == DRV_COMPL |-> ls_drive[0] == !hs_drive[0];
  endproperty
  a_compl: assert property (p_compl) else $error("phase a not complementary");

  property p_disabled;
    !st_ff.en ##1 !st_ff.en |-> st_ff.cnt == CNT_ZERO ##1 (!hs_drive[0] || $past(st_ff.sel[0]) == DRV_HS_ON);
  endproperty
  a_disabled: assert property (p_disabled) else $error("generator runs while disabled");

  property p_count_up;
    st_ff.en && st_ff.cmode == CNT_UP && st_ff.cnt < st_ff.period |=> st_ff.cnt == $past(st_ff.cnt) + CNT_ONE;
  endproperty
  a_count_up: assert property (p_count_up) else $error("up count wrong");

  property p_pwm_cmp;
    $past(st_ff.sel[1]) == DRV_HS_PWM |-> hs_drive[1] == $past(st_ff.en && st_ff.cnt < st_ff.duty[1]);
  endproperty
  a_pwm_cmp: assert property (p_pwm_cmp) else $error("pwm compare wrong");
endmodule // three_phase_pwm_gen_regs

/* File: src/pwm_gen_pkg.sv */
// three-phase pwm generator: register map, field layout, reset values, drive codes
// assumes a 16-bit register word reached through the serial register port
package pwm_gen_pkg;
  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned DATA_W    = 16;
  localparam int unsigned VAL_W     = 12;
  localparam int unsigned SEL_W     = 3;
  localparam int unsigned NPH       = 3;

  // register offsets
  localparam logic [7:0] OFS_PERIOD = 8'h18;
  localparam logic [7:0] OFS_DUTY_A = 8'h19;
  localparam logic [7:0] OFS_DUTY_B = 8'h1a;
  localparam logic [7:0] OFS_DUTY_C = 8'h1b;
  localparam logic [7:0] OFS_STATE  = 8'h1c;
  localparam logic [7:0] OFS_CTRL   = 8'h1d;

  // reset values
  localparam logic [15:0] RST_DUTY   = 16'h0000;
  localparam logic [15:0] RST_STATE  = 16'h0777;
  localparam logic [15:0] RST_CTRL   = 16'h0000;
  localparam logic [11:0] RST_PERIOD = 12'h000;

  // field positions
  localparam int unsigned PAR_BIT     = 15;
  localparam int unsigned SEL_A_LSB   = 0;
  localparam int unsigned SEL_B_LSB   = 4;
  localparam int unsigned SEL_C_LSB   = 8;
  localparam int unsigned EN_BIT      = 10;
  localparam int unsigned CMODE_LSB   = 8;
  localparam int unsigned SYNC_LSB    = 5;
  localparam int unsigned SCLK_LSB    = 2;
  localparam int unsigned ACC_LSB     = 0;

  // phase drive selector codes
  localparam logic [2:0] DRV_OFF     = 3'h0;
  localparam logic [2:0] DRV_LS_ON   = 3'h1;
  localparam logic [2:0] DRV_HS_ON   = 3'h2;
  localparam logic [2:0] DRV_LS_PWM  = 3'h5;
  localparam logic [2:0] DRV_HS_PWM  = 3'h6;
  localparam logic [2:0] DRV_COMPL   = 3'h7;

  // counter mode codes
  localparam logic [1:0] CNT_UPDOWN  = 2'h0;
  localparam logic [1:0] CNT_UP      = 2'h1;
  localparam logic [1:0] CNT_DOWN    = 2'h2;
  localparam logic [1:0] CNT_HOLD    = 2'h3;

  localparam logic [11:0] CNT_ZERO   = 12'h000;
  localparam logic [11:0] CNT_ONE    = 12'h001;
endpackage

/* File: src/drive_if.sv */
// carries per-phase selector, pwm and resulting switch commands between core and decoder
// assumes one entry per phase, index 0 = phase a
`timescale 1ns/1ps
interface drive_if;
  import pwm_gen_pkg::*;
  logic [NPH-1:0][SEL_W-1:0] sel;
  logic [NPH-1:0]            pwm;
  logic [NPH-1:0]            hs;
  logic [NPH-1:0]            ls;
  modport core (output sel, output pwm, input hs, input ls);
  modport drv  (input sel, input pwm, output hs, output ls);
endinterface

/* File: src/phase_drive.sv */
// decodes each phase selector and pwm level into high- and low-side commands
// assumes the core registers the results before they leave the block
`timescale 1ns/1ps
module phase_drive
  import pwm_gen_pkg::*;
(
  drive_if.drv d
);
  genvar i;
  generate
    for (i = 0; i < NPH; i++) begin : g_ph
      // reserved codes fall to both switches off
      always_comb begin
        d.hs[i] = 1'b0;
        d.ls[i] = 1'b0;
        case (d.sel[i])
          DRV_OFF: begin
            d.hs[i] = 1'b0;
            d.ls[i] = 1'b0;
          end
          DRV_LS_ON: d.ls[i] = 1'b1;
          DRV_HS_ON: d.hs[i] = 1'b1;
          DRV_LS_PWM: d.ls[i] = d.pwm[i];
          DRV_HS_PWM: d.hs[i] = d.pwm[i];
          DRV_COMPL: begin
            d.hs[i] = d.pwm[i];
            d.ls[i] = ~d.pwm[i];
          end
          default: begin
            d.hs[i] = 1'b0;
            d.ls[i] = 1'b0;
          end
        endcase
      end
    end
  endgenerate
endmodule // phase_drive

/* File: test/host_model.sv */
// host side of the register port: strobed single-word writes and reads
// assumes the block samples strobes on the rising edge and answers reads one cycle later
`timescale 1ns/1ps
module host_model
  import pwm_gen_pkg::*;
(
  input  wire logic              clk,
  output logic                   reg_wr,
  output logic                   reg_rd,
  output logic      [ADDR_W-1:0] reg_addr,
  output logic      [DATA_W-1:0] reg_wdata,
  input  wire logic [DATA_W-1:0] reg_rdata
);
  // idle bus shows the inverse of the last value so a stale read cannot pass
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'hff;
    reg_wdata = 16'hffff;
  end

  // one strobe cycle, launched and released on falling edges; the idle cycle in front keeps strobes apart
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(negedge clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clk);
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask

  // data is taken one cycle after the strobe edge, where it stands
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge clk);
    reg_rd   = 1'b0;
    reg_addr = ~a;
    d        = reg_rdata;
  endtask
endmodule // host_model

/* File: test/test_three_phase_pwm_gen_regs.sv */
// self-checking bench for the three-phase pwm register block
// assumes the host model drives the register port and the bench owns reset and parity enable
`timescale 1ns/1ps
module test_three_phase_pwm_gen_regs;
  import pwm_gen_pkg::*;
  logic              clk;
  logic              nrst;
  logic              pen;
  logic              wr_s;
  logic              rd_s;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic [NPH-1:0]    hs;
  logic [NPH-1:0]    ls;
  logic              act;
  int                err_count = 0;
  int                compares = 0;
  int                na, nb, nc;
  logic              eh, el;

  three_phase_pwm_gen_regs three_phase_pwm_gen_regs_inst (.clk(clk), .nrst(nrst), .serial_check_enable(pen),
    .reg_wr(wr_s), .reg_rd(rd_s), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
    .hs_drive(hs), .ls_drive(ls), .gen_active(act));
  host_model host_model_inst (.clk(clk), .reg_wr(wr_s), .reg_rd(rd_s), .reg_addr(addr),
    .reg_wdata(wdata), .reg_rdata(rdata));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] v;
    host_model_inst.rd(a, v);
    chk(v, exp);
  endtask

  // writes reach the drive outputs two edges after the strobe; wait past that
  task automatic settle();
    repeat (3) @(negedge clk);
  endtask

  // counts high cycles per phase over a whole number of counter periods
  task automatic count_hi(input int n);
    na = 0;
    nb = 0;
    nc = 0;
    repeat (n) begin
      @(negedge clk);
      na += int'(hs[0] === 1'b1);
      nb += int'(hs[1] === 1'b1);
      nc += int'(hs[2] === 1'b1);
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // hang guard, far beyond the few hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    close_out();
  end

  initial begin
    nrst = 1'b0;
    pen  = 1'b0;
    repeat (6) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    rd_chk(OFS_DUTY_A, 16'h0000);
    rd_chk(OFS_DUTY_B, 16'h0000);
    rd_chk(OFS_DUTY_C, 16'h0000);
    rd_chk(OFS_STATE, 16'h0777);
    rd_chk(OFS_CTRL, 16'h0000);
    chk({10'h0, hs, ls}, 16'h0007);
    // parity only appears while checking is on; even over the whole word
    pen = 1'b1;
    rd_chk(OFS_STATE, 16'h8777);
    host_model_inst.wr(OFS_DUTY_A, 16'h0003);
    rd_chk(OFS_DUTY_A, 16'h0003);
    host_model_inst.wr(OFS_DUTY_A, 16'h0001);
    rd_chk(OFS_DUTY_A, 16'h8001);
    pen = 1'b0;
    // read-only and reserved bits ignore all-ones writes
    host_model_inst.wr(OFS_DUTY_A, 16'hffff);
    rd_chk(OFS_DUTY_A, 16'h0fff);
    host_model_inst.wr(OFS_DUTY_C, 16'hf5a5);
    rd_chk(OFS_DUTY_C, 16'h05a5);
    host_model_inst.wr(OFS_STATE, 16'hffff);
    rd_chk(OFS_STATE, 16'h0777);
    host_model_inst.wr(OFS_PERIOD, 16'hf003);
    rd_chk(OFS_PERIOD, 16'h0003);
    host_model_inst.wr(OFS_CTRL, 16'hffff);
    rd_chk(OFS_CTRL, 16'h07ff);
    settle();
    chk({15'h0, act}, 16'h0001);
    host_model_inst.wr(8'h20, 16'h1234);
    rd_chk(8'h20, 16'h0000);
    // every selector code with pwm low (disabled) then pwm high (held count 0 below duty 1)
    host_model_inst.wr(OFS_DUTY_A, 16'h0001);
    host_model_inst.wr(OFS_DUTY_B, 16'h0001);
    host_model_inst.wr(OFS_DUTY_C, 16'h0001);
    for (int p = 0; p < 2; p++) begin
      host_model_inst.wr(OFS_CTRL, (p == 1) ? 16'h0700 : 16'h0000);
      for (int c = 0; c < 8; c++) begin
        host_model_inst.wr(OFS_STATE, {5'h0, c[2:0], 1'b0, c[2:0], 1'b0, c[2:0]});
        settle();
        eh = (c == 2) || ((c == 6 || c == 7) && p == 1);
        el = (c == 1) || (c == 5 && p == 1) || (c == 7 && p == 0);
        chk({10'h0, hs, ls}, {10'h0, {3{eh}}, {3{el}}});
      end
    end
    // period 3: up-down gives a 6-cycle frame, up and down a 4-cycle one; duties 2, 1, 0
    host_model_inst.wr(OFS_DUTY_A, 16'h0002);
    host_model_inst.wr(OFS_DUTY_C, 16'h0000);
    host_model_inst.wr(OFS_STATE, 16'h0666);
    for (int m = 0; m < 3; m++) begin
      host_model_inst.wr(OFS_CTRL, 16'h0400 | 16'(m << 8));
      settle();
      count_hi((m == 0) ? 12 : 8);
      chk({na[3:0], nb[3:0], nc[3:0]}, (m == 0) ? 12'h620 : 12'h420);
    end
    host_model_inst.wr(OFS_CTRL, 16'h0000);
    settle();
    count_hi(8);
    chk({na[3:0], nb[3:0], nc[3:0], 3'h0, act}, 16'h0000);
    close_out();
  end
endmodule // test_three_phase_pwm_gen_regs
